// >>> hdl/pma_pkg.sv
// constants, field layouts and carrier types of the power monitor accumulator
// assumes one 10 MHz clock domain and a 32-bit classic wishbone register bus

package pma_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int ADC_W  = 12;
    localparam int SUM_W  = 19;
    localparam int PWR_W  = 25;
    localparam int ACC_W  = 24;
    localparam int ROLL_W = 8;
    localparam int CNT_W  = 24;
    localparam int SMP_W  = 8;

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [7:0] ADR_MON_CONFIG  = 8'h00;
    localparam logic [7:0] ADR_MON_CONTROL = 8'h04;
    localparam logic [7:0] ADR_STATUS      = 8'h08;
    localparam logic [7:0] ADR_VOLT        = 8'h0C;
    localparam logic [7:0] ADR_CURR        = 8'h10;
    localparam logic [7:0] ADR_AUX         = 8'h14;
    localparam logic [7:0] ADR_POWER       = 8'h18;
    localparam logic [7:0] ADR_EIN_ACC     = 8'h1C;
    localparam logic [7:0] ADR_EIN_ROLL    = 8'h20;
    localparam logic [7:0] ADR_EIN_CNT     = 8'h24;
    localparam logic [7:0] ADR_PEAK_CURR   = 8'h28;
    localparam logic [7:0] ADR_PEAK_VOLT   = 8'h2C;
    localparam logic [7:0] ADR_PEAK_AUX    = 8'h30;
    localparam logic [7:0] ADR_PEAK_CLR    = 8'h34;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTL_EXTERNAL_TRIGGER_MODE_BIT    = 0;
    localparam int CTL_GROUP_BIT   = 1;
    localparam int STS_BUSY_BIT    = 0;
    localparam int STS_GROUP_BIT   = 1;
    localparam int STS_EXTERNAL_TRIGGER_MODE_BIT    = 2;
    localparam int PCLR_CURR_BIT   = 0;
    localparam int PCLR_VOLT_BIT   = 1;
    localparam int PCLR_AUX_BIT    = 2;

    // ************************************************************
    // adc channel codes
    // ************************************************************
    localparam logic [1:0] CH_VOLT = 2'h0;
    localparam logic [1:0] CH_CURR = 2'h1;
    localparam logic [1:0] CH_AUX  = 2'h2;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic       gpo_level;
        logic       external_trigger_mode;
        logic       aux_en;
        logic       range50;
        logic [2:0] avg_n;
        logic       single;
    } pma_cfg_t;

    typedef struct packed {
        logic [ADC_W-1:0] aux;
        logic [ADC_W-1:0] curr;
        logic [ADC_W-1:0] volt;
    } pma_meas_t;

    localparam pma_cfg_t CFG_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_WAIT,
        ST_CALC,
        ST_POWER
    } pma_state_t;

endpackage

// >>> hdl/pma_peak.sv
// peak holding register for one measured channel
// assumes load_i is a one-cycle pulse with value_i stable in that cycle

module pma_peak
    import pma_pkg::*;
#(
    parameter int W         = 12,
    parameter bit IS_SIGNED = 1'b0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         clear_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic      [W-1:0] peak_o
);

    logic         higher;
    logic [W-1:0] peak_r;

    assign higher = IS_SIGNED ? ($signed(value_i) > $signed(peak_r))
                              : (value_i > peak_r);
    assign peak_o = peak_r;

    // new sample wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            peak_r <= '0; // R17
        end else if (load_i && (higher || clear_i)) begin
            peak_r <= value_i; // R6
        end else if (clear_i) begin
            peak_r <= '0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_peak_hold: // R6
    assert property (load_i && higher |=> peak_r == $past(value_i))
        else $error("peak not taken from higher sample");

endmodule

// >>> hdl/pma_top.sv
// power monitor sequencer, averager, power and energy accumulator
// assumes an adc front end on the same clock and a classic wishbone master;
// i2c pins and the shared trigger pin are asynchronous and synchronised here
//
// The register addresses and register access over Wishbone were decided locally.

// Function
// R1 - sample current, voltage, optionally auxiliary
// R2 - power is voltage times current
// R3 - add each power into readable accumulator; negative power adds zero here
// R4 - rollover on overflow, count every sample
// R5 - accumulator, rollover, count read together
// R6 - per channel peak since last clear
// R7 - average over two power n samples
// R8 - signed current, 25 or 50 mV range
// R9 - single shot gives one averaged result
// R10 - continuous keeps latest result readable
// R11 - continuous mode after reset
// R12 - single mode plus convert bit starts
// R13 - group convert waits for stop condition
// R14 - trigger pin edge starts single shot
// R15 - latest power readable as input power
// R16 - host derives energy from deltas
// R17 - accumulators and peaks zero at reset
module pma_top
    import pma_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  adc_start_o,
    output logic      [1:0]       adc_chan_o,
    output logic                  adc_range50_o,
    input  wire logic             adc_done_i,
    input  wire logic [ADC_W-1:0] adc_data_i,
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    input  wire logic             shared_output_trigger_pin_i,
    output logic                  shared_output_trigger_pin_o,
    output logic                  shared_output_trigger_pin_oe_n_o
);

    // ************************************************************
    // declarations
    // ************************************************************
    pma_cfg_t                cfg_r;
    pma_state_t              state_r;
    pma_meas_t               res_r;
    logic                    ack_r;
    logic [31:0]             dat_r;
    logic [31:0]             rd_data;
    logic                    wb_hit;
    logic                    wr_en;
    logic                    rd_en;
    logic                    wr_ctl;
    logic                    external_trigger_mode_now;
    logic                    group_set;
    logic                    group_pend_r;
    logic                    external_trigger_mode_pend_r;
    logic                    go;
    logic                    take;
    logic [2:0]              scl_s_r;
    logic [2:0]              sda_s_r;
    logic [2:0]              pin_s_r;
    logic                    stop_w;
    logic                    trig_edge;
    logic                    adc_start_r;
    logic [1:0]              chan_r;
    logic [SMP_W-1:0]        samp_r;
    logic [SMP_W-1:0]        last_w;
    logic [2:0]              avg_run_r;
    logic                    aux_run_r;
    logic [SUM_W-1:0]        sum_v_r;
    logic signed [SUM_W-1:0] sum_i_r;
    logic [SUM_W-1:0]        sum_a_r;
    logic                    sample_end;
    logic signed [PWR_W-1:0] pwr_nxt;
    logic signed [PWR_W-1:0] power_r;
    logic [ACC_W-1:0]        pwr_pos;
    logic [ACC_W:0]          acc_sum;
    logic [ACC_W-1:0]        acc_r;
    logic [ROLL_W-1:0]       roll_r;
    logic [CNT_W-1:0]        cnt_r;
    logic [ROLL_W-1:0]       snap_roll_r;
    logic [CNT_W-1:0]        snap_cnt_r;
    logic                    peak_load;
    logic [2:0]              peak_clr;
    logic [ADC_W-1:0]        peak_curr;
    logic [ADC_W-1:0]        peak_volt;
    logic [ADC_W-1:0]        peak_aux;

    // ************************************************************
    // wishbone slave
    // ************************************************************
    // one wait state: ack rises the cycle after the strobe, read data with it
    assign wb_hit   = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_en    = wb_hit && wb_we_i && wb_sel_i[0];
    assign rd_en    = wb_hit && !wb_we_i;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_hit;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            ADR_MON_CONFIG:  rd_data = 32'(cfg_r);
            ADR_STATUS: begin
                rd_data[STS_BUSY_BIT]  = (state_r != ST_IDLE);
                rd_data[STS_GROUP_BIT] = group_pend_r;
                rd_data[STS_EXTERNAL_TRIGGER_MODE_BIT]  = external_trigger_mode_pend_r;
            end
            ADR_VOLT:        rd_data = 32'(res_r.volt);
            ADR_CURR:        rd_data = 32'($signed(res_r.curr)); // R8
            ADR_AUX:         rd_data = 32'(res_r.aux);
            ADR_POWER:       rd_data = 32'(power_r); // R15
            ADR_EIN_ACC:     rd_data = 32'(acc_r); // R5
            ADR_EIN_ROLL:    rd_data = 32'(snap_roll_r);
            ADR_EIN_CNT:     rd_data = 32'(snap_cnt_r);
            ADR_PEAK_CURR:   rd_data = 32'($signed(peak_curr));
            ADR_PEAK_VOLT:   rd_data = 32'(peak_volt);
            ADR_PEAK_AUX:    rd_data = 32'(peak_aux);
            default:         rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (rd_en) begin
            dat_r <= rd_data;
        end
    end

    // reading the accumulator freezes the two counters beside it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snap_roll_r <= '0;
            snap_cnt_r  <= '0;
        end else if (rd_en && wb_adr_i == ADR_EIN_ACC) begin
            snap_roll_r <= roll_r; // R5
            snap_cnt_r  <= cnt_r; // R5
        end
    end

    // ************************************************************
    // configuration
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= CFG_RESET; // R11
        end else if (wr_en && wb_adr_i == ADR_MON_CONFIG) begin
            cfg_r <= pma_cfg_t'(wb_dat_i[7:0]);
        end
    end

    // range select goes straight to the analog front end
    assign adc_range50_o = cfg_r.range50; // R8
    // pin is released while it serves as the trigger input
    assign shared_output_trigger_pin_o      = cfg_r.gpo_level;
    assign shared_output_trigger_pin_oe_n_o = cfg_r.external_trigger_mode;

    assign peak_clr = (wr_en && wb_adr_i == ADR_PEAK_CLR) ? wb_dat_i[2:0]
                                                          : 3'h0;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            pin_s_r <= 3'h0;
        end else begin
            scl_s_r <= {scl_s_r[1:0], scl_i};
            sda_s_r <= {sda_s_r[1:0], sda_i};
            pin_s_r <= {pin_s_r[1:0], shared_output_trigger_pin_i};
        end
    end

    // stop: sda rises while scl stays high; bit 0 is only read by bit 1
    assign stop_w    = scl_s_r[2] && scl_s_r[1] && sda_s_r[1] && !sda_s_r[2];
    assign trig_edge = cfg_r.external_trigger_mode
                       && pin_s_r[1] && !pin_s_r[2]; // R14

    // ************************************************************
    // conversion requests
    // ************************************************************
    assign wr_ctl    = wr_en && wb_adr_i == ADR_MON_CONTROL;
    assign external_trigger_mode_now  = wr_ctl && cfg_r.single && wb_dat_i[CTL_EXTERNAL_TRIGGER_MODE_BIT]
                       && !wb_dat_i[CTL_GROUP_BIT]; // R12
    assign group_set = wr_ctl && cfg_r.single && wb_dat_i[CTL_EXTERNAL_TRIGGER_MODE_BIT]
                       && wb_dat_i[CTL_GROUP_BIT];
    assign go        = !cfg_r.single || external_trigger_mode_pend_r; // R10
    assign take      = (state_r == ST_IDLE) && go;

    // a new request wins over the clear of the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            group_pend_r <= 1'b0;
        end else begin
            group_pend_r <= group_set || (group_pend_r && !stop_w); // R13
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            external_trigger_mode_pend_r <= 1'b0;
        end else begin
            external_trigger_mode_pend_r <= external_trigger_mode_now || trig_edge
                           || (stop_w && group_pend_r) // R13
                           || (external_trigger_mode_pend_r && !take);
        end
    end

    // ************************************************************
    // sampling sequencer
    // ************************************************************
    assign last_w     = SMP_W'((9'h001 << avg_run_r) - 9'h001); // R7
    assign sample_end = adc_done_i && ((chan_r == CH_AUX)
                        || (chan_r == CH_CURR && !aux_run_r)); // R1
    assign adc_start_o = adc_start_r;
    assign adc_chan_o  = chan_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= ST_IDLE;
            adc_start_r <= 1'b0;
            chan_r      <= CH_VOLT;
            samp_r      <= '0;
            avg_run_r   <= 3'h0;
            aux_run_r   <= 1'b0;
        end else begin
            adc_start_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        state_r   <= ST_START;
                        chan_r    <= CH_VOLT;
                        samp_r    <= '0;
                        avg_run_r <= cfg_r.avg_n; // R7
                        aux_run_r <= cfg_r.aux_en; // R1
                    end
                end
                ST_START: begin
                    adc_start_r <= 1'b1;
                    state_r     <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (sample_end && samp_r == last_w) begin
                        state_r <= ST_CALC; // R9
                    end else if (sample_end) begin
                        samp_r  <= samp_r + 1'b1;
                        chan_r  <= CH_VOLT;
                        state_r <= ST_START;
                    end else if (adc_done_i) begin
                        chan_r  <= (chan_r == CH_VOLT) ? CH_CURR : CH_AUX;
                        state_r <= ST_START;
                    end
                end
                ST_CALC:  state_r <= ST_POWER;
                ST_POWER: state_r <= ST_IDLE;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // averaging
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || take) begin
            sum_v_r <= '0;
            sum_i_r <= '0;
            sum_a_r <= '0;
        end else if (state_r == ST_WAIT && adc_done_i) begin
            case (chan_r)
                CH_VOLT: sum_v_r <= sum_v_r + SUM_W'(adc_data_i);
                CH_CURR: sum_i_r <= sum_i_r + SUM_W'($signed(adc_data_i));
                CH_AUX:  sum_a_r <= sum_a_r + SUM_W'(adc_data_i);
                default: sum_v_r <= sum_v_r;
            endcase
        end
    end

    // results only move once per run, so a read never sees a partial one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_r <= '0;
        end else if (state_r == ST_CALC) begin
            res_r.volt <= ADC_W'(sum_v_r >> avg_run_r); // R7
            res_r.curr <= ADC_W'(sum_i_r >>> avg_run_r); // R8
            if (aux_run_r) begin
                res_r.aux <= ADC_W'(sum_a_r >> avg_run_r);
            end
        end
    end

    // ************************************************************
    // power and energy
    // ************************************************************
    // negative power is not accumulated: energy only counts delivered power
    assign pwr_nxt = $signed({1'b0, res_r.volt}) * $signed(res_r.curr); // R2
    assign pwr_pos = pwr_nxt[PWR_W-1] ? '0 : pwr_nxt[ACC_W-1:0];
    assign acc_sum = {1'b0, acc_r} + {1'b0, pwr_pos};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_r <= '0;
        end else if (state_r == ST_POWER) begin
            power_r <= pwr_nxt; // R2
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r  <= '0; // R17
            roll_r <= '0;
            cnt_r  <= '0;
        end else if (state_r == ST_POWER) begin
            acc_r <= acc_sum[ACC_W-1:0]; // R3
            cnt_r <= cnt_r + 1'b1; // R4
            if (acc_sum[ACC_W]) begin
                roll_r <= roll_r + 1'b1; // R4
            end
        end
    end

    // ************************************************************
    // peaks
    // ************************************************************
    assign peak_load = (state_r == ST_POWER);

    pma_peak #(.W(ADC_W), .IS_SIGNED(1'b1)) u_peak_curr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (peak_clr[PCLR_CURR_BIT]),
        .load_i  (peak_load),
        .value_i (res_r.curr),
        .peak_o  (peak_curr)
    );

    pma_peak #(.W(ADC_W), .IS_SIGNED(1'b0)) u_peak_volt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (peak_clr[PCLR_VOLT_BIT]),
        .load_i  (peak_load),
        .value_i (res_r.volt),
        .peak_o  (peak_volt)
    );

    pma_peak #(.W(ADC_W), .IS_SIGNED(1'b0)) u_peak_aux (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (peak_clr[PCLR_AUX_BIT]),
        .load_i  (peak_load && aux_run_r),
        .value_i (res_r.aux),
        .peak_o  (peak_aux)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_power_product: // R2
    assert property (state_r == ST_POWER |=> power_r ==
                     $signed({1'b0, res_r.volt}) * $signed(res_r.curr))
        else $error("power is not volt times current");
    a_acc_add: // R3
    assert property (state_r == ST_POWER |=>
                     acc_r == ACC_W'($past(acc_r) + $past(pwr_pos)))
        else $error("accumulator did not add power");
    a_count_step: // R4
    assert property (state_r == ST_POWER |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("sample count did not step");
    a_roll_step: // R4
    assert property (state_r == ST_POWER && acc_sum[ACC_W] |=>
                     roll_r == $past(roll_r) + 1'b1)
        else $error("rollover count did not step");
    a_ein_snapshot: // R5
    assert property (rd_en && wb_adr_i == ADR_EIN_ACC |=>
                     snap_cnt_r == $past(cnt_r) && dat_r == 32'($past(acc_r)))
        else $error("energy snapshot not coherent");
    a_avg_count: // R7
    assert property (state_r == ST_CALC |-> samp_r == last_w)
        else $error("wrong number of samples averaged");
    a_single_wait: // R9
    assert property (state_r == ST_IDLE && cfg_r.single && !external_trigger_mode_pend_r
                     |=> state_r == ST_IDLE)
        else $error("single shot ran without a request");
    // a config write landing with the last power cycle may end the loop
    a_cont_loop: // R10
    assert property (state_r == ST_POWER ##1 !cfg_r.single
                     |-> state_r == ST_IDLE ##1 state_r == ST_START)
        else $error("continuous mode did not restart");
    a_group_defer: // R13
    assert property (group_set && !external_trigger_mode_pend_r && !trig_edge
                     |=> !external_trigger_mode_pend_r)
        else $error("group convert started before stop");
    a_trig_start: // R14
    assert property (trig_edge && state_r != ST_IDLE |=> external_trigger_mode_pend_r)
        else $error("trigger edge lost");
    a_reset_zero: // R17
    assert property (@(posedge clk_i) disable iff (1'b0)
                     rst_i |=> acc_r == '0 && cnt_r == '0
                     && roll_r == '0 && cfg_r == CFG_RESET)
        else $error("accumulators not cleared by reset");

    c_single_done: cover property (cfg_r.single && state_r == ST_POWER);
    c_group_stop:  cover property (stop_w && group_pend_r);
    c_rollover:    cover property (state_r == ST_POWER && acc_sum[ACC_W]);
    c_trigger:     cover property (trig_edge && state_r == ST_IDLE);

endmodule

// >>> tb/pma_adc_model.sv
// adc front end model: answers each start with one sample three cycles later
// assumes start_i is a one-cycle pulse and chan_i holds until done
module pma_adc_model
    import pma_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             start_i,
    input  wire logic [1:0]       chan_i,
    input  wire pma_meas_t        meas_i,
    input  wire logic             wob_i,
    output logic                  done_o,
    output logic      [ADC_W-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;
    logic [1:0] ch_r;
    logic       tog_r;
    // data only valid with done; inverted otherwise so stale reads show
    always_ff @(posedge clk_i) begin
        done_o <= (cnt_r == 2'h1);
        data_o <= ~data_o;
        if (rst_i) begin
            cnt_r <= 2'h0;
            tog_r <= 1'b0;
        end else if (start_i) begin
            cnt_r <= 2'h2;
            ch_r <= chan_i;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end
        // wobble adds 2 to every other volt sample to expose averaging
        if (cnt_r == 2'h1) begin
            tog_r <= tog_r ^ (ch_r == CH_VOLT);
            data_o <= (ch_r == CH_CURR) ? meas_i.curr :
                      (ch_r == CH_AUX) ? meas_i.aux :
                      meas_i.volt + ADC_W'({tog_r & wob_i, 1'b0});
        end
    end
endmodule

// >>> tb/pma_top_bench.sv
// self-checking bench of pma_top driven over classic wishbone
// assumes pma_pkg and the adc model of pma_adc_model.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module pma_top_bench
    import pma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, ack, start, r50, done, pin_o, pin_oe_n;
    logic        scl = 1'b1, sda = 1'b1, pin = 1'b0, wob = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, d;
    logic [1:0]  chan;
    logic [11:0] adata;
    pma_meas_t   meas = {12'h055, 12'h010, 12'h100};
    int          mismatches = 0, compares = 0;
    longint      eacc, eroll, ecnt;
    pma_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .adc_start_o(start), .adc_chan_o(chan), .adc_range50_o(r50),
        .adc_done_i(done), .adc_data_i(adata), .scl_i(scl), .sda_i(sda),
        .shared_output_trigger_pin_i(pin),
        .shared_output_trigger_pin_o(pin_o),
        .shared_output_trigger_pin_oe_n_o(pin_oe_n));
    pma_adc_model adc_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
        .chan_i(chan), .meas_i(meas), .wob_i(wob), .done_o(done),
        .data_o(adata));
    task print_verdict;
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // the master waits for ack with no assumed latency
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(d, e)
    endtask
    task single(input int k, input logic [11:0] vavg);
        int n;
        if (k == 2) begin
            @(posedge clk_i);
            pin <= 1'b1;
            repeat (6) @(posedge clk_i);
            pin <= 1'b0;
        end else xfer(1'b1, ADR_MON_CONTROL, (k == 1) ? 32'h3 : 32'h1);
        if (k == 1) begin
            rd(ADR_STATUS, 32'h2);
            sda <= 1'b0;
            repeat (4) @(posedge clk_i);
            sda <= 1'b1;
        end
        repeat (8) @(posedge clk_i);
        n = 0;
        do begin
            xfer(1'b0, ADR_STATUS, 32'h0);
            n++;
        end while ((d[STS_BUSY_BIT] !== 1'b0 || d[STS_EXTERNAL_TRIGGER_MODE_BIT] !== 1'b0)
                   && n < 100);
        if (n >= 100) mismatches++;
        ecnt++;
        // host side energy bookkeeping; negative power adds nothing
        eacc += (longint'(vavg) * longint'($signed(meas.curr)) > 0) ?
                longint'(vavg) * longint'($signed(meas.curr)) : 0;
        eroll += eacc / 64'h1000000;
        eacc = eacc % 64'h1000000;
    endtask
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADR_MON_CONFIG, 32'h0);
        rd(ADR_EIN_ACC, 32'h0);
        rd(ADR_PEAK_AUX, 32'h0);
        repeat (60) @(posedge clk_i);
        rd(ADR_VOLT, 32'h100);
        rd(ADR_CURR, 32'h10);
        rd(ADR_POWER, 32'h1000);
        meas.curr <= 12'h020;
        repeat (60) @(posedge clk_i);
        rd(ADR_POWER, 32'h2000);
        xfer(1'b1, ADR_MON_CONFIG, 32'h05);
        single(3, 12'h000);
        xfer(1'b0, ADR_EIN_ACC, 32'h0);
        eacc = d;
        xfer(1'b0, ADR_EIN_ROLL, 32'h0);
        eroll = d;
        xfer(1'b0, ADR_EIN_CNT, 32'h0);
        ecnt = d;
        wob <= 1'b1;
        single(0, 12'h101);
        wob <= 1'b0;
        rd(ADR_VOLT, 32'h101);
        xfer(1'b1, ADR_MON_CONFIG, 32'h21);
        single(1, 12'h100);
        rd(ADR_AUX, 32'h55);
        rd(ADR_PEAK_AUX, 32'h55);
        xfer(1'b1, ADR_MON_CONFIG, 32'hD1);
        repeat (2) @(posedge clk_i);
        `CHK(r50, 1'b1)
        `CHK(pin_oe_n, 1'b1)
        `CHK(pin_o, 1'b1)
        meas.volt <= 12'hFFF;
        meas.curr <= 12'h7FF;
        single(2, 12'hFFF);
        single(2, 12'hFFF);
        single(0, 12'hFFF);
        rd(ADR_PEAK_VOLT, 32'hFFF);
        rd(ADR_PEAK_CURR, 32'h7FF);
        xfer(1'b1, ADR_PEAK_CLR, 32'h2);
        rd(ADR_PEAK_VOLT, 32'h0);
        meas.curr <= 12'hFF0;
        single(0, 12'hFFF);
        rd(ADR_CURR, 32'hFFFFFFF0);
        rd(ADR_POWER, 32'hFFFF0010);
        rd(ADR_EIN_ACC, 32'(eacc));
        rd(ADR_EIN_ROLL, 32'(eroll));
        rd(ADR_EIN_CNT, 32'(ecnt));
        print_verdict;
    end
endmodule
